// ===== rtl/pio_cell.sv
// I/O cell register logic: input capture, output drive and tri-state register.
// Assumes configuration is written over Wishbone before traffic and left alone after.
// Functional notes
// - Bypass routes pad to combinational and clock outputs
// - Optional fixed input delay before capture
// - Bottom cells take five-bit run-time delay code
// - SDR input captured once per rising edge
// - DDR input sampled on both clock edges
// - SDR output from register or transparent latch
// - DDR output captures both core bits rising
// - Falling edge moves second bit to register
// - Clock-driven mux alternates the two output registers
// - Tri-state control registered then drives buffer
// - One system clock for all three blocks
// - Local set/reset loads configured initial values
//
// Implementation choices: the placing of the registers and the Wishbone register port.
module pio_cell #(
   parameter bit BOTTOM_EDGE = 1'b1                 // Cell sits on the bottom edge
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Cell controls from the core
   input  wire logic        ce_i,
   input  wire logic        lsr_i,
   input  wire logic [4:0]  dyn_lag_code_i,
   // Pad side
   input  wire logic        pad_in_i,
   output logic             pad_out_o,
   output logic             pad_oe_o,
   output logic             tristate_to_buffer_o,
   // Core side
   output logic             bypass_comb_in_o,
   output logic             bypass_clock_out_o,
   output logic             rise_capture_o,
   output logic             fall_capture_o,
   input  wire logic        core_out_first_i,
   input  wire logic        core_out_second_i,
   input  wire logic        core_tristate_ctl_i
);
   // Word decode shared by read and write paths
   function automatic logic pio_hit(input logic [3:0] adr, input logic [3:0] off);
      pio_hit = (adr[3:2] == off[3:2]);
   endfunction

   pio_pkg::pio_cfg_s    cfg;            // Live configuration
   pio_pkg::pio_cfg_s    next_cfg;       // Configuration after a write
   pio_pkg::pio_wb_req_s req;            // Bundled bus request
   logic                 ack;            // Registered acknowledge
   logic [31:0]          rd_data;        // Registered read data
   logic [4:0]           lag_tap;        // Selected delay taps
   logic                 lag_data;       // Pad after delay
   logic                 rise_q;         // Rising-edge input capture
   logic                 fall_q;         // Falling-edge input capture
   logic                 out_r0;         // First output register
   logic                 out_r1pre;      // Second core bit, rising capture
   logic                 out_r1;         // Second output register, falling
   logic                 latch_hold;     // Latch content while opaque
   logic                 tq;             // Tri-state register
   logic                 hold;           // Registers keep their value
   logic                 req_live;       // Request present on the bus
   logic                 do_write;       // Write commits this edge
   logic                 hit_ctrl;       // Control register addressed
   logic                 hit_stat;       // Status register addressed
   logic [31:0]          status_word;    // Live cell state for reads
   logic [31:0]          next_rd_data;   // Read mux result
   logic                 latch_open;     // Latch currently transparent
   logic                 sdr_out;        // SDR output element value

   // Bus decode
   assign req          = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
   assign req_live     = req.cyc & req.stb;
   assign hit_ctrl     = pio_hit(req.adr, pio_pkg::PIO_CTRL_OFF);
   assign hit_stat     = pio_hit(req.adr, pio_pkg::PIO_STATUS_OFF);
   // Write lands on the edge where the master sees ack, never earlier
   assign do_write     = req_live & req.we & ack & hit_ctrl;

   // Byte lanes: lane 0 holds the mode bits, lane 1 the tri-state initial value
   assign next_cfg     = pio_pkg::pio_cfg_s'({req.sel[1] ? req.dat[8] : cfg.ts_init,
                                               req.sel[0] ? req.dat[7:0] : cfg[7:0]});

   assign status_word  = {19'h0_0000, lag_tap, 3'h0, tq, out_r1, out_r0, fall_capture_o, rise_capture_o};
   // Unmapped words read as zero and are still acknowledged
   assign next_rd_data = hit_ctrl ? {23'h00_0000, cfg} : hit_stat ? status_word : pio_pkg::PIO_ZERO_WORD;

   // Configuration store, changed only by software
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cfg <= pio_pkg::PIO_CTRL_RST;
      else if (do_write)
         cfg <= next_cfg;
   end

   // One-cycle acknowledge with read data registered alongside
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack     <= 1'b0;
         rd_data <= pio_pkg::PIO_ZERO_WORD;
      end
      else
      begin
         ack     <= req_live & ~ack;
         rd_data <= (req_live & ~ack) ? next_rd_data : rd_data;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rd_data;

   // Clock enable low freezes every cell register; local set/reset still wins
   assign hold = ~ce_i;

   // Delay selection: run-time code wins over the fixed delay on bottom cells
   assign lag_tap = (BOTTOM_EDGE && cfg.dyn_lag_en) ? dyn_lag_code_i :
                    cfg.fixed_lag_en ? pio_pkg::PIO_FIXED_TAPS :
                    pio_pkg::PIO_NO_TAPS;

   pio_lag_line u_lag (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .din_i  (pad_in_i),
      .tap_i  (lag_tap),
      .dout_o (lag_data)
   );

   // Bypass is purely combinational, so it carries no register latency
   assign bypass_comb_in_o   = cfg.bypass_en & pad_in_i;
   assign bypass_clock_out_o = cfg.bypass_en & pad_in_i;

   // Rising-edge input register, also the SDR capture register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rise_q <= 1'b0;
      else if (lsr_i)
         rise_q <= cfg.in_init;
      else if (!hold)
         rise_q <= lag_data;
   end

   // Falling-edge input register for double-rate capture
   always_ff @(negedge clk_i)
   begin
      if (rst_i)
         fall_q <= 1'b0;
      else if (lsr_i)
         fall_q <= cfg.in_init;
      else if (!hold && cfg.in_ddr)
         fall_q <= lag_data;
   end

   // SDR result appears on the registered-input output
   assign rise_capture_o = rise_q;
   assign fall_capture_o = cfg.in_ddr ? fall_q : rise_q;

   // Rising-edge output registers for both core bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         out_r0    <= 1'b0;
         out_r1pre <= 1'b0;
      end
      else if (lsr_i)
      begin
         out_r0    <= cfg.out_init;
         out_r1pre <= cfg.out_init;
      end
      else if (!hold)
      begin
         out_r0    <= core_out_first_i;
         out_r1pre <= core_out_second_i;
      end
   end

   // Second bit moves on the falling edge so it is stable for the low phase
   always_ff @(negedge clk_i)
   begin
      if (rst_i)
         out_r1 <= 1'b0;
      else if (lsr_i)
         out_r1 <= cfg.out_init;
      else if (!hold)
         out_r1 <= out_r1pre;
   end

   // Latch closes on the falling edge and keeps the last transparent value
   always_ff @(negedge clk_i)
   begin
      if (rst_i)
         latch_hold <= 1'b0;
      else if (lsr_i)
         latch_hold <= cfg.out_init;
      else if (!hold)
         latch_hold <= core_out_first_i;
   end

   // Latch is transparent while the clock is high and enabled
   assign latch_open = clk_i & ce_i & ~lsr_i;
   assign sdr_out    = cfg.out_latch ? (latch_open ? core_out_first_i : latch_hold) : out_r0;

   // High phase shows the first register, low phase the second
   assign pad_out_o  = cfg.out_ddr ? (clk_i ? out_r0 : out_r1) : sdr_out;

   // Tri-state register, high means pad released
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tq <= 1'b1;
      else if (lsr_i)
         tq <= cfg.ts_init;
      else if (!hold)
         tq <= core_tristate_ctl_i;
   end

   assign tristate_to_buffer_o = tq;
   assign pad_oe_o             = ~tq;

   // Checks
   chk_bypass_path: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg.bypass_en |-> (bypass_comb_in_o == pad_in_i) && (bypass_clock_out_o == pad_in_i))
      else $error("bypass output differs from pad");

   chk_fixed_tap: assert property (@(posedge clk_i) disable iff (rst_i)
      (cfg.fixed_lag_en && !(BOTTOM_EDGE && cfg.dyn_lag_en)) |-> lag_tap == pio_pkg::PIO_FIXED_TAPS)
      else $error("fixed delay tap not selected");

   chk_dyn_tap: assert property (@(posedge clk_i) disable iff (rst_i)
      (BOTTOM_EDGE && cfg.dyn_lag_en) |-> lag_tap == dyn_lag_code_i)
      else $error("dynamic delay code ignored");

   chk_sdr_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !lsr_i && !cfg.in_ddr) |=> fall_capture_o == $past(lag_data))
      else $error("sdr input capture wrong");

   chk_fall_sample: assert property (@(negedge clk_i) disable iff (rst_i)
      (ce_i && !lsr_i && cfg.in_ddr) |=> fall_q == $past(lag_data))
      else $error("falling edge input sample wrong");

   chk_sdr_reg_out: assert property (@(posedge clk_i) disable iff (rst_i)
      (!cfg.out_ddr && !cfg.out_latch && ce_i && !lsr_i) |=> pad_out_o == $past(core_out_first_i))
      else $error("sdr output register wrong");

   chk_ddr_capture: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !lsr_i) |=> (out_r0 == $past(core_out_first_i)) && (out_r1pre == $past(core_out_second_i)))
      else $error("ddr output capture wrong");

   chk_ddr_transfer: assert property (@(negedge clk_i) disable iff (rst_i)
      (ce_i && !lsr_i) |=> out_r1 == $past(out_r1pre))
      else $error("second output bit not transferred");

   chk_ddr_mux_low: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg.out_ddr |-> pad_out_o == out_r1)
      else $error("low phase does not show second register");

   chk_tri_reg: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !lsr_i) |=> (tristate_to_buffer_o == $past(core_tristate_ctl_i)) && (pad_oe_o != tq))
      else $error("tri-state register wrong");

   chk_lsr_init: assert property (@(posedge clk_i) disable iff (rst_i)
      lsr_i |=> (tq == $past(cfg.ts_init)) && (out_r0 == $past(cfg.out_init)) && (rise_q == $past(cfg.in_init)))
      else $error("local reset did not load initial values");

   chk_ce_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ce_i && !lsr_i) |=> $stable(tq) && $stable(out_r0) && $stable(rise_q))
      else $error("register changed with clock enable low");

   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   chk_bypass_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg.bypass_en |-> !bypass_comb_in_o && !bypass_clock_out_o)
      else $error("bypass outputs active while disabled");

   chk_rise_sample: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !lsr_i) |=> rise_capture_o == $past(lag_data))
      else $error("rising edge input sample wrong");

   // At the falling edge the sampled clock still reads high, so these see the high phase
   chk_latch_open: assert property (@(negedge clk_i) disable iff (rst_i)
      (cfg.out_latch && !cfg.out_ddr && ce_i && !lsr_i) |-> pad_out_o == core_out_first_i)
      else $error("latch not transparent in high phase");

   chk_ddr_mux_high: assert property (@(negedge clk_i) disable iff (rst_i)
      cfg.out_ddr |-> pad_out_o == out_r0)
      else $error("high phase does not show first register");

   chk_cfg_static: assert property (@(posedge clk_i) disable iff (rst_i)
      !do_write |=> $stable(cfg))
      else $error("configuration changed without a bus write");
endmodule

// ===== rtl/pio_lag_line.sv
// Tapped delay line that models the selectable input delay in whole clock cycles.
// Assumes tap changes only while the cell is idle; a tap of zero is a straight wire.
module pio_lag_line (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       din_i,
   input  wire logic [4:0] tap_i,
   output logic            dout_o
);
   logic [pio_pkg::PIO_LAG_DEPTH-1:0] stage;   // Delay stages, stage[0] is newest

   // First stage follows the input each cycle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stage[0] <= 1'b0;
      else
         stage[0] <= din_i;
   end

   // Remaining stages shift one per cycle
   genvar g;
   generate
      for (g = 1; g < pio_pkg::PIO_LAG_DEPTH; g++)
      begin : g_stage
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               stage[g] <= 1'b0;
            else
               stage[g] <= stage[g-1];
         end
      end
   endgenerate

   // Tap zero bypasses the line so no delay costs no latency
   assign dout_o = (tap_i == pio_pkg::PIO_NO_TAPS) ? din_i : stage[tap_i - 5'd1];
endmodule

// ===== rtl/pio_pkg.sv
// Shared constants and types for the programmable I/O cell register logic.
// Assumes one 250 MHz system clock and a classic Wishbone master for configuration.
package pio_pkg;
   // Register byte offsets on the Wishbone bus
   localparam logic [3:0]  PIO_CTRL_OFF    = 4'h0;
   localparam logic [3:0]  PIO_STATUS_OFF  = 4'h4;
   // Reset values
   localparam logic [8:0]  PIO_CTRL_RST    = 9'h000;
   localparam logic [31:0] PIO_ZERO_WORD   = 32'h0000_0000;
   // Delay line geometry, in system clock cycles per tap
   localparam int          PIO_LAG_DEPTH   = 32;
   localparam logic [4:0]  PIO_FIXED_TAPS  = 5'h04;
   localparam logic [4:0]  PIO_NO_TAPS     = 5'h00;
   // Status word field positions
   localparam int          PIO_ST_RISE     = 0;
   localparam int          PIO_ST_FALL     = 1;
   localparam int          PIO_ST_OUT0     = 2;
   localparam int          PIO_ST_OUT1     = 3;
   localparam int          PIO_ST_TRI      = 4;
   localparam int          PIO_ST_TAP      = 8;

   // Static cell configuration, bit 0 is bypass_en
   typedef struct packed {
      logic ts_init;       // Tri-state register initial value
      logic out_init;      // Output registers initial value
      logic in_init;       // Input registers initial value
      logic out_latch;     // SDR output element is a latch
      logic out_ddr;       // Double-rate output
      logic in_ddr;        // Double-rate input
      logic dyn_lag_en;    // Use the run-time delay code
      logic fixed_lag_en;  // Use the fixed delay
      logic bypass_en;     // Route pad around registers
   } pio_cfg_s;

   // Wishbone request carrier
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pio_wb_req_s;
endpackage

// ===== tb/pio_pad_model.sv
// Pad buffer model that stands between the cell and the board.
// Assumes the bench plays the board side through ext_i.
module pio_pad_model (
   input  wire logic pad_out_i,
   input  wire logic pad_oe_i,
   input  wire logic ext_i,
   output logic      pad_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // The cell wins the wire while its enable is high
   assign pad_o = pad_oe_i ? pad_out_i : ext_i;
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the I/O cell register logic.
// Assumes one 4 ns clock; config written over Wishbone only while idle.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0;     // System clock
   logic        rst_i = 1;     // Sync reset
   logic        cyc = 0, stb = 0, we = 0;
   logic [3:0]  adr = 0;
   logic [31:0] wdat = 0;
   logic        ce_i = 1, lsr_i = 0, ext = 0;
   logic        d0 = 0, d1 = 0, td = 1; // Core outputs
   logic [4:0]  dyn = 0;       // Run-time delay code
   logic [31:0] rdat, rd;
   logic        ack, pad_out, pad_oe, tq, bcomb, bclk, rcap, fcap, pad;
   int          n_fail = 0, n_tests = 0, n;

   pio_cell dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .ce_i(ce_i), .lsr_i(lsr_i), .dyn_lag_code_i(dyn), .pad_in_i(pad),
      .pad_out_o(pad_out), .pad_oe_o(pad_oe), .tristate_to_buffer_o(tq),
      .bypass_comb_in_o(bcomb), .bypass_clock_out_o(bclk), .rise_capture_o(rcap),
      .fall_capture_o(fcap), .core_out_first_i(d0), .core_out_second_i(d1),
      .core_tristate_ctl_i(td));
   pio_pad_model pad_u (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext), .pad_o(pad));

   // Free-running clock
   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // One compare for every kind of result
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic single Wishbone cycle; waits for ack, bounded
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
      k = 0;
      do
      begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 50);
      rd = rdat;
      if (k >= 50)
         chk("ack", 1, 0);
      cyc <= 0; stb <= 0; we <= 0;
   endtask

   // Sample just after an edge, once its updates have landed
   task automatic rise_wait();
      @(posedge clk_i);
      #1;
   endtask

   // Edges from a pad step until the capture shows it
   task automatic lat();
      ext <= 0;
      repeat (40) @(posedge clk_i);
      ext <= 1;
      n = 0;
      do
      begin
         rise_wait();
         n++;
      end while (rcap !== 1'b1 && n < 40);
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard, far beyond the few hundred cycles used
   initial
   begin
      #200us;
      n_fail++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      xfer(0, 4'h4, 0);
      chk("status rst", 32'h0000_0010, rd);
      chk("oe rst", 0, pad_oe);
      xfer(0, 4'h0, 0);
      chk("ctrl rst", 0, rd);
      xfer(1, 4'h8, 32'hFFFF_FFFF);
      xfer(0, 4'h8, 0);
      chk("unmapped", 0, rd);
      // Bypass follows the pad at once
      xfer(1, 4'h0, 32'h0000_0001);
      xfer(0, 4'h0, 0);
      chk("ctrl rb", 32'h0000_0001, rd);
      @(posedge clk_i) ext <= 1;
      #1 chk("byp comb", 1, bcomb);
      chk("byp clk", 1, bclk);
      @(posedge clk_i) ext <= 0;
      #1 chk("byp low", 0, bcomb);
      // Plain SDR capture, then hold with enable low
      xfer(1, 4'h0, 0);
      lat();
      chk("sdr lat", 1, n);
      chk("sdr fall", 1, fcap);
      chk("byp off", 0, bclk);
      @(posedge clk_i) begin ce_i <= 0; ext <= 0; end
      repeat (3) rise_wait();
      chk("ce hold", 1, rcap);
      @(posedge clk_i) ce_i <= 1;
      // Fixed and run-time delays
      xfer(1, 4'h0, 32'h0000_0002);
      xfer(0, 4'h4, 0);
      chk("tap fix", 4, rd[12:8]);
      lat();
      chk("fix lat", 5, n);
      dyn <= 5'h07;
      xfer(1, 4'h0, 32'h0000_0004);
      lat();
      chk("dyn lat", 8, n);
      // DDR input: both edges sampled
      xfer(1, 4'h0, 32'h0000_0008);
      // Rising sample takes the 1, the falling sample after it the 0
      @(posedge clk_i) ext <= 0;
      @(posedge clk_i) ext <= 1;
      @(posedge clk_i) ext <= 0;
      @(negedge clk_i) #1;
      chk("ddr rise", 1, rcap);
      chk("ddr fall", 0, fcap);
      // SDR output register and tri-state register
      xfer(1, 4'h0, 0);
      @(posedge clk_i) begin d0 <= 1; td <= 0; end
      #1 chk("reg old", 0, pad_out);
      rise_wait();
      chk("reg out", 1, pad_out);
      chk("tq", 0, tq);
      chk("oe", 1, pad_oe);
      // Latch is transparent while the clock is high
      xfer(1, 4'h0, 32'h0000_0020);
      @(posedge clk_i) d0 <= 0;
      #1 chk("latch", 0, pad_out);
      // DDR output: first bit in high phase, second in low
      xfer(1, 4'h0, 32'h0000_0010);
      // Release the pad so the clock-phase mux cannot race the input capture
      @(posedge clk_i) begin d0 <= 1; d1 <= 0; td <= 1; end
      rise_wait();
      chk("ddr hi", 1, pad_out);
      @(negedge clk_i) #1;
      chk("ddr lo", 0, pad_out);
      @(posedge clk_i) begin d0 <= 0; d1 <= 1; end
      rise_wait();
      chk("ddr hi2", 0, pad_out);
      @(negedge clk_i) #1;
      chk("ddr lo2", 1, pad_out);
      // Local set/reset loads the chosen initial values
      xfer(1, 4'h0, 32'h0000_00C0);
      @(posedge clk_i) begin lsr_i <= 1; ext <= 0; td <= 1; end
      rise_wait();
      chk("lsr in", 1, rcap);
      chk("lsr out", 1, pad_out);
      chk("lsr ts", 0, tq);
      @(posedge clk_i) lsr_i <= 0;
      // Let the checks that span the local reset complete
      repeat (2) @(posedge clk_i);
      tally_and_finish();
   end
endmodule
